// ---- led_scan_pkg.sv ----
`default_nettype none
package led_scan_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   // Register indices, byte address is four times the index
   localparam logic [7:0] IDX_SCAN_OPEN = 8'hAF;
   localparam logic [7:0] IDX_SCAN_CONTROL = 8'hB0;
   localparam logic [7:0] IDX_ON_TIME_ONE = 8'hB1;
   localparam logic [7:0] IDX_ON_TIME_TWO = 8'hB2;
   localparam logic [7:0] IDX_DRIVE_STRENGTH = 8'hB3;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'hC0;
   localparam logic [7:0] IDX_IRQ_MASK = 8'hC1;
   // Field positions
   localparam int OPEN_BIT = 0;
   localparam int LOCK_BIT = 0;
   localparam int MODE_BIT = 1;
   localparam int SIZE_LSB = 2;
   localparam int SIZE_W = 3;
   localparam int DRIVE_W = 4;
   localparam int PASS_DONE_BIT = 0;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_DRIVE = 4'h0;
   // Matrix geometry
   localparam int LINES = 9;
   localparam int IDX_W = 4;
   // Time base
   localparam int TICK_NS = 16000;
   localparam int CLK_PERIOD_NS = 8;
   localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam int TICK_CNT_W = 11;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_LIGHT = 3'b010,
      ST_WAIT = 3'b100
   } scan_state_t;

   // Number of lines used by a matrix size code
   function automatic logic [IDX_W-1:0] lines_of(input logic [2:0] size);
      logic [IDX_W-1:0] n;
      n = 4'h0;
      unique case (size)
         3'h0: n = 4'h0;
         3'h1: n = 4'h5;
         3'h2: n = 4'h6;
         3'h3: n = 4'h7;
         3'h4, 3'h5, 3'h6: n = 4'h8;
         3'h7: n = 4'h9;
      endcase
      return n;
   endfunction
endpackage
`default_nettype wire

// ---- led_scan_tick.sv ----
`default_nettype none
module led_scan_tick
   import led_scan_pkg::*;
#(
   parameter int CYCLES = TICK_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clear,
   output logic tick
);
   logic [TICK_CNT_W-1:0] cnt_r;
   logic [TICK_CNT_W-1:0] cnt_nxt;

   if (CYCLES < 2 || CYCLES > (1 << TICK_CNT_W)) begin : g_chk
      $error("led_scan_tick: CYCLES out of range");
   end

   always_comb begin
      tick = 1'b0;
      cnt_nxt = cnt_r + 1'b1;
      if (clear) begin
         cnt_nxt = '0;
      end else if (cnt_r == TICK_CNT_W'(CYCLES - 1)) begin
         tick = 1'b1;
         cnt_nxt = '0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule
`default_nettype wire

// ---- led_matrix_scan_control.sv ----
// Summary of operation
// - Size code zero disables; 1-3 small matrices
// - Codes 4-7 select larger matrices, lines
// - Mode bit: one cycle scan, zero interrupt
// - Lock bit one locks commons as IO
// - Lock bit zero leaves commons unlocked
// - While locked, scan settings have no effect
// - On-time one lasts (value+1) times 16us
// - On-time two lasts (value+1) times 16us
//
// Implementation choice: the AXI4-Lite slave port.
`default_nettype none
module led_matrix_scan_control
   import led_scan_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [LINES-1:0] lamp_pattern_one,
   input wire logic [LINES-1:0] lamp_pattern_two,
   output logic [LINES-1:0] matrix_lines_out,
   output logic [LINES-1:0] matrix_lines_oe,
   output logic [IDX_W-1:0] scan_line_index,
   output logic scan_slot,
   output logic common_port_sink_lock,
   output logic [DRIVE_W-1:0] drive_strength,
   output logic scan_irq
);
   // Register file
   logic open_r, open_nxt;
   logic [4:0] ctrl_r, ctrl_nxt;
   logic [7:0] on_one_r, on_one_nxt;
   logic [7:0] on_two_r, on_two_nxt;
   logic [DRIVE_W-1:0] drive_r, drive_nxt;
   logic status_r, status_nxt;
   logic mask_r, mask_nxt;
   // Bus state
   logic aw_held_r, aw_held_nxt;
   logic w_held_r, w_held_nxt;
   logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
   logic [7:0] wbyte_r, wbyte_nxt;
   logic wlane_r, wlane_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic [7:0] rbyte_r, rbyte_nxt;
   // Scan state
   scan_state_t state_r, state_nxt;
   logic [IDX_W-1:0] idx_r, idx_nxt;
   logic slot_r, slot_nxt;
   logic [7:0] tcnt_r, tcnt_nxt;
   logic [LINES-1:0] out_r, out_nxt;
   logic [LINES-1:0] oe_r, oe_nxt;

   logic [2:0] size;
   logic lock;
   logic mode_cycle;
   logic [IDX_W-1:0] nlines;
   logic run_ok;
   logic tick;
   logic pass_end;
   logic slot_end;
   logic do_write;
   logic wr_ok;
   logic [7:0] widx;
   logic [7:0] ridx;
   logic rd_ok;

   assign size = ctrl_r[SIZE_LSB +: SIZE_W];
   assign lock = ctrl_r[LOCK_BIT];
   assign mode_cycle = ctrl_r[MODE_BIT];
   assign nlines = lines_of(size);
   // Locked commons or no matrix keep the scanner idle
   assign run_ok = open_r && (size != 3'h0) && !lock;

   led_scan_tick #(
      .CYCLES(TICK_LEN)
   ) u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(state_r != ST_LIGHT),
      .tick(tick)
   );

   // AXI4-Lite slave
   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready = !w_held_r && !bvalid_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = {24'h000000, rbyte_r};
   assign do_write = aw_held_r && w_held_r;
   assign widx = awaddr_r[9:2];
   assign wr_ok = (awaddr_r[ADDR_W-1:10] == '0) &&
                  ((widx >= IDX_SCAN_OPEN && widx <= IDX_DRIVE_STRENGTH) ||
                   widx == IDX_IRQ_STATUS || widx == IDX_IRQ_MASK);
   assign ridx = s_axi_araddr[9:2];
   assign rd_ok = (s_axi_araddr[ADDR_W-1:10] == '0) &&
                  ((ridx >= IDX_SCAN_OPEN && ridx <= IDX_DRIVE_STRENGTH) ||
                   ridx == IDX_IRQ_STATUS || ridx == IDX_IRQ_MASK);

   always_comb begin
      aw_held_nxt = aw_held_r;
      w_held_nxt = w_held_r;
      awaddr_nxt = awaddr_r;
      wbyte_nxt = wbyte_r;
      wlane_nxt = wlane_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rbyte_nxt = rbyte_r;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_held_nxt = 1'b1;
         awaddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_held_nxt = 1'b1;
         wbyte_nxt = s_axi_wdata[7:0];
         wlane_nxt = s_axi_wstrb[0];
      end
      if (do_write) begin
         aw_held_nxt = 1'b0;
         w_held_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = rd_ok ? RESP_OKAY : RESP_SLVERR;
         rbyte_nxt = 8'h00;
         unique case (ridx)
            IDX_SCAN_OPEN: rbyte_nxt = {7'h00, open_r};
            IDX_SCAN_CONTROL: rbyte_nxt = {3'h0, ctrl_r};
            IDX_ON_TIME_ONE: rbyte_nxt = on_one_r;
            IDX_ON_TIME_TWO: rbyte_nxt = on_two_r;
            IDX_DRIVE_STRENGTH: rbyte_nxt = {4'h0, drive_r};
            IDX_IRQ_STATUS: rbyte_nxt = {7'h00, status_r};
            IDX_IRQ_MASK: rbyte_nxt = {7'h00, mask_r};
            default: rbyte_nxt = 8'h00;
         endcase
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= '0;
         wbyte_r <= 8'h00;
         wlane_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         rvalid_r <= 1'b0;
         rresp_r <= RESP_OKAY;
         rbyte_r <= 8'h00;
      end else begin
         aw_held_r <= aw_held_nxt;
         w_held_r <= w_held_nxt;
         awaddr_r <= awaddr_nxt;
         wbyte_r <= wbyte_nxt;
         wlane_r <= wlane_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rbyte_r <= rbyte_nxt;
      end
   end

   // Register writes; pass-done set wins over its clear
   always_comb begin
      open_nxt = open_r;
      ctrl_nxt = ctrl_r;
      on_one_nxt = on_one_r;
      on_two_nxt = on_two_r;
      drive_nxt = drive_r;
      mask_nxt = mask_r;
      status_nxt = status_r;
      if (do_write && wlane_r) begin
         unique case (widx)
            IDX_SCAN_OPEN: open_nxt = wbyte_r[OPEN_BIT];
            IDX_SCAN_CONTROL: ctrl_nxt = wbyte_r[4:0];
            IDX_ON_TIME_ONE: on_one_nxt = wbyte_r;
            IDX_ON_TIME_TWO: on_two_nxt = wbyte_r;
            IDX_DRIVE_STRENGTH: drive_nxt = wbyte_r[DRIVE_W-1:0];
            IDX_IRQ_STATUS: status_nxt = status_r & ~wbyte_r[PASS_DONE_BIT];
            IDX_IRQ_MASK: mask_nxt = wbyte_r[PASS_DONE_BIT];
            default: ;
         endcase
      end
      if (pass_end) begin
         status_nxt = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         open_r <= RST_BYTE[0];
         ctrl_r <= RST_BYTE[4:0];
         on_one_r <= RST_BYTE;
         on_two_r <= RST_BYTE;
         drive_r <= RST_DRIVE;
         status_r <= 1'b0;
         mask_r <= 1'b0;
      end else begin
         open_r <= open_nxt;
         ctrl_r <= ctrl_nxt;
         on_one_r <= on_one_nxt;
         on_two_r <= on_two_nxt;
         drive_r <= drive_nxt;
         status_r <= status_nxt;
         mask_r <= mask_nxt;
      end
   end

   assign scan_irq = status_r && mask_r;
   assign common_port_sink_lock = lock;
   assign drive_strength = drive_r;
   assign scan_line_index = idx_r;
   assign scan_slot = slot_r;
   assign matrix_lines_out = out_r;
   assign matrix_lines_oe = oe_r;

   // Scan sequencer
   assign slot_end = (state_r == ST_LIGHT) && tick &&
                     (tcnt_r == (slot_r ? on_two_r : on_one_r));
   assign pass_end = run_ok && slot_end && slot_r && (idx_r == nlines - 1'b1);

   always_comb begin
      state_nxt = state_r;
      idx_nxt = idx_r;
      slot_nxt = slot_r;
      tcnt_nxt = tcnt_r;
      out_nxt = '0;
      oe_nxt = '0;
      unique case (state_r)
         ST_IDLE: begin
            idx_nxt = '0;
            slot_nxt = 1'b0;
            tcnt_nxt = 8'h00;
            if (run_ok) begin
               state_nxt = ST_LIGHT;
            end
         end
         ST_LIGHT: begin
            if (tick) begin
               tcnt_nxt = tcnt_r + 1'b1;
            end
            if (slot_end) begin
               tcnt_nxt = 8'h00;
               slot_nxt = !slot_r;
               if (slot_r) begin
                  if (pass_end) begin
                     idx_nxt = '0;
                     if (!mode_cycle) begin
                        state_nxt = ST_WAIT;
                     end
                  end else begin
                     idx_nxt = idx_r + 1'b1;
                  end
               end
            end
         end
         ST_WAIT: begin
            if (!status_r) begin
               state_nxt = ST_LIGHT;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
      if (!run_ok) begin
         state_nxt = ST_IDLE;
      end
      // Common line high, pattern lines sink within the matrix
      if (state_nxt == ST_LIGHT) begin
         for (int j = 0; j < LINES; j++) begin
            if (j < int'(nlines)) begin
               if (j == int'(idx_nxt)) begin
                  out_nxt[j] = 1'b1;
                  oe_nxt[j] = 1'b1;
               end else if (slot_nxt ? lamp_pattern_two[j]
                                     : lamp_pattern_one[j]) begin
                  oe_nxt[j] = 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= ST_IDLE;
         idx_r <= '0;
         slot_r <= 1'b0;
         tcnt_r <= 8'h00;
         out_r <= '0;
         oe_r <= '0;
      end else begin
         state_r <= state_nxt;
         idx_r <= idx_nxt;
         slot_r <= slot_nxt;
         tcnt_r <= tcnt_nxt;
         out_r <= out_nxt;
         oe_r <= oe_nxt;
      end
   end

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   size_zero_a: assert property ((size == 3'h0) |=> (oe_r == '0))
      else $error("lines driven with no matrix");
   line_range_a: assert property ((oe_r != '0) |->
      ((oe_r >> $past(nlines)) == '0))
      else $error("line outside matrix driven");
   mode_cycle_a: assert property ((pass_end && mode_cycle) |=>
      (state_r == ST_LIGHT && idx_r == '0))
      else $error("cycle scan did not restart");
   lock_out_a: assert property (lock |-> common_port_sink_lock)
      else $error("lock not shown");
   unlock_out_a: assert property (!lock |-> !common_port_sink_lock)
      else $error("commons locked while bit clear");
   lock_idle_a: assert property (lock |=>
      (state_r == ST_IDLE && oe_r == '0))
      else $error("scan active while locked");
   slot_one_a: assert property ((slot_end && !slot_r) |->
      (tcnt_r == on_one_r) ##1 slot_r)
      else $error("slot one length wrong");
   slot_two_a: assert property ((tick && state_r == ST_LIGHT && slot_r &&
      tcnt_r != on_two_r && run_ok) |=> slot_r)
      else $error("slot two ended early");
   open_stop_a: assert property ($fell(open_r) |->
      ##1 (state_r == ST_IDLE && oe_r == '0))
      else $error("scan did not stop");
   irq_wait_a: assert property ((pass_end && !mode_cycle) |=>
      (status_r && state_r == ST_WAIT))
      else $error("interrupt pass did not wait");
endmodule
`default_nettype wire

// ---- led_display_model.sv ----
`default_nettype none
module led_display_model
   import led_scan_pkg::*;
(
   input wire logic aclk,
   input wire logic clr,
   input wire logic [LINES-1:0] matrix_lines_out,
   input wire logic [LINES-1:0] matrix_lines_oe,
   output logic [IDX_W-1:0] top_line,
   output logic bad_common
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [LINES-1:0] hi;
   // Lines driven high form the common of the lit column
   assign hi = matrix_lines_out & matrix_lines_oe;
   always_ff @(posedge aclk) begin
      if (clr) begin
         top_line <= '0;
         bad_common <= 1'b0;
      end else begin
         // Only one common line may source at a time
         if ($countones(hi) > 1) begin
            bad_common <= 1'b1;
         end
         // Highest common line reached in this pass
         for (int i = 0; i < LINES; i++) begin
            if (hi[i] && i > int'(top_line)) begin
               top_line <= IDX_W'(i);
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- led_matrix_scan_control_tb.sv ----
`default_nettype none
module led_matrix_scan_control_tb
   import led_scan_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TL = 4;
   logic aclk, aresetn, clr, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, slot, lock, irq, bad;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [3:0] wstrb, drv;
   logic [1:0] bresp, rresp;
   logic [LINES-1:0] pat1, pat2, lout, oe;
   logic [IDX_W-1:0] idx, top;
   logic [33:0] exp_r[$];
   logic [1:0] exp_b[$];
   int mismatches = 0;
   int checks = 0;
   int nl [8] = '{0, 5, 6, 7, 8, 8, 8, 9};
   logic [7:0] regs [7] = '{IDX_SCAN_OPEN, IDX_SCAN_CONTROL, IDX_ON_TIME_ONE,
      IDX_ON_TIME_TWO, IDX_DRIVE_STRENGTH, IDX_IRQ_STATUS, IDX_IRQ_MASK};

   led_matrix_scan_control #(.TICK_LEN(TL)) DUT (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .lamp_pattern_one(pat1), .lamp_pattern_two(pat2),
      .matrix_lines_out(lout), .matrix_lines_oe(oe), .scan_line_index(idx),
      .scan_slot(slot), .common_port_sink_lock(lock), .drive_strength(drv),
      .scan_irq(irq));

   led_display_model display (.aclk(aclk), .clr(clr), .matrix_lines_out(lout),
      .matrix_lines_oe(oe), .top_line(top), .bad_common(bad));

   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   task automatic chk(input string nm, input logic [33:0] s, e);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic summarize();
      if (mismatches == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic axw(input logic [7:0] i, d, input logic [1:0] r = RESP_OKAY);
      bit a, w;
      a = 0;
      w = 0;
      exp_b.push_back(r);
      awaddr <= {2'h0, i, 2'h0};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(a && w)) begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) begin
            a = 1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready === 1'b1) begin
            w = 1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
   endtask

   task automatic axr(input logic [7:0] i, d, input logic [1:0] r = RESP_OKAY);
      exp_r.push_back({r, 24'h0, d});
      araddr <= {2'h0, i, 2'h0};
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
   endtask

   task automatic wirq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 400) begin
         @(posedge aclk);
         n++;
      end
      chk("irq", irq, 1);
   endtask

   task automatic gap(input bit ix, output int n);
      logic [IDX_W-1:0] i0;
      logic s0;
      i0 = idx;
      s0 = slot;
      n = 0;
      while (ix ? idx === i0 : slot === s0) begin
         @(posedge aclk);
         n++;
      end
   endtask

   // Response watcher takes the oldest note on each answer
   always @(posedge aclk) begin
      if (rvalid === 1'b1 && rready) begin
         chk("rdata", {rresp, rdata}, exp_r.pop_front());
      end
      if (bvalid === 1'b1 && bready) begin
         chk("bresp", bresp, exp_b.pop_front());
      end
   end

   always @(posedge aclk) begin
      pat1 <= LINES'($urandom);
      pat2 <= LINES'($urandom);
   end

   initial begin
      cyc(20000);
      mismatches++;
      summarize();
   end

   initial begin
      logic [7:0] d;
      int n;
      void'($urandom(32'h64ED));
      {aresetn, clr, awvalid, wvalid, arvalid} <= 5'h08;
      {awaddr, araddr, wdata} <= '0;
      {pat1, pat2} <= '0;
      {bready, rready} <= 2'h3;
      wstrb <= 4'hF;
      cyc(16);
      aresetn <= 1'b1;
      clr <= 1'b0;
      cyc(1);
      foreach (regs[k]) axr(regs[k], 8'h00);
      axr(8'hB4, 8'h00, RESP_SLVERR);
      axw(8'hB4, 8'hFF, RESP_SLVERR);
      d = 8'($urandom);
      axw(IDX_ON_TIME_ONE, d);
      axr(IDX_ON_TIME_ONE, d);
      d = 8'($urandom);
      axw(IDX_ON_TIME_TWO, d);
      axr(IDX_ON_TIME_TWO, d);
      d = 8'($urandom);
      axw(IDX_DRIVE_STRENGTH, d);
      chk("drive", drv, d[3:0]);
      axw(IDX_ON_TIME_ONE, 8'h00);
      axw(IDX_ON_TIME_TWO, 8'h00);
      axw(IDX_IRQ_MASK, 8'h01);
      for (int s = 1; s < 8; s++) begin
         axw(IDX_SCAN_OPEN, 8'h00);
         axw(IDX_SCAN_CONTROL, 8'(s * 4 + 2));
         axw(IDX_IRQ_STATUS, 8'h01);
         clr <= 1'b1;
         cyc(1);
         clr <= 1'b0;
         axw(IDX_SCAN_OPEN, 8'h01);
         wirq();
         chk("top line", top, nl[s] - 1);
         cyc(2);
         chk("restart", {idx, |oe}, {4'h0, 1'b1});
      end
      axw(IDX_ON_TIME_ONE, 8'h02);
      axw(IDX_ON_TIME_TWO, 8'h01);
      while (slot !== 1'b0) @(posedge aclk);
      while (slot !== 1'b1) @(posedge aclk);
      gap(1, n);
      chk("slot two", n, 2 * TL);
      gap(0, n);
      chk("slot one", n, 3 * TL);
      axw(IDX_SCAN_OPEN, 8'h00);
      axw(IDX_ON_TIME_ONE, 8'h00);
      axw(IDX_ON_TIME_TWO, 8'h00);
      axw(IDX_SCAN_CONTROL, 8'h04);
      axw(IDX_IRQ_STATUS, 8'h01);
      axw(IDX_SCAN_OPEN, 8'h01);
      wirq();
      cyc(8);
      chk("wait oe", oe, 0);
      axr(IDX_IRQ_STATUS, 8'h01);
      axw(IDX_IRQ_MASK, 8'h00);
      cyc(1);
      chk("masked irq", irq, 0);
      axw(IDX_IRQ_MASK, 8'h01);
      axw(IDX_IRQ_STATUS, 8'h01);
      cyc(2);
      chk("resume", {irq, |oe}, 2'b01);
      axw(IDX_SCAN_CONTROL, 8'h07);
      cyc(4);
      chk("lock", {lock, oe}, {1'b1, 9'h000});
      axw(IDX_SCAN_CONTROL, 8'h06);
      cyc(4);
      chk("unlock", {lock, |oe}, 2'b01);
      axw(IDX_SCAN_CONTROL, 8'h02);
      cyc(2);
      chk("size zero", oe, 0);
      axw(IDX_SCAN_CONTROL, 8'h06);
      axw(IDX_SCAN_OPEN, 8'h00);
      cyc(2);
      chk("closed", oe, 0);
      chk("common", bad, 0);
      summarize();
   end
endmodule
`default_nettype wire
